// file: dv/cell_cluster_props.sv
`timescale 1ns/1ps
`default_nettype none

module cell_cluster_props #(
  parameter int N_CELLS = 16
) (
  // apb side
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_psel,
  input wire logic               i_penable,
  input wire logic               i_pwrite,
  input wire logic [11:0]        i_paddr,
  input wire logic [31:0]        i_pwdata,
  input wire logic               o_pready,
  input wire logic [31:0]        o_prdata,
  input wire logic               o_pslverr,
  // fabric side
  input wire logic               i_carry_in,
  input wire logic [N_CELLS-1:0] o_route_a,
  input wire logic [N_CELLS-1:0] o_route_b,
  input wire logic [N_CELLS-1:0] o_local,
  input wire logic               o_carry_out,
  input wire logic               o_reg_chain_out
);
  // map decode; cell words past N_CELLS are holes
  wire logic [11:0] cell_end = cell_cluster_pkg::OFS_CELL0
                               + 12'(4 * N_CELLS);
  wire logic        access   = i_psel && i_penable;
  wire logic        is_ctrl  = i_paddr == cell_cluster_pkg::OFS_CTRL;
  wire logic        is_stat  = i_paddr == cell_cluster_pkg::OFS_STATUS;
  wire logic        is_cell  = i_paddr >= cell_cluster_pkg::OFS_CELL0
                               && i_paddr < cell_end && i_paddr[1:0] == 2'h0;
  wire logic        mapped   = is_ctrl || is_stat || is_cell;
  // non-global slots asked for by a control write
  wire logic [7:0]  nonglob  = i_pwdata[15:8] & ~i_pwdata[23:16];
  wire logic        over     = $countones(nonglob)
                               > cell_cluster_pkg::NONGLOBAL_MAX;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_zero_wait;
    o_pready == access;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("pready not tied to access");
  property p_hole;
    access && !mapped |-> o_pslverr && (i_pwrite || o_prdata == 32'h0);
  endproperty
  a_hole: assert property (p_hole)
    else $error("hole access not refused");
  property p_read_ok;
    access && mapped && !i_pwrite |-> !o_pslverr;
  endproperty
  a_read_ok: assert property (p_read_ok)
    else $error("mapped read refused");
  property p_status_ro;
    access && i_pwrite && is_stat |-> o_pslverr;
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status write accepted");
  property p_budget;
    access && i_pwrite && is_ctrl && over |-> o_pslverr;
  endproperty
  a_budget: assert property (p_budget)
    else $error("control budget exceeded without refusal");
  property p_stands;
    access |=> $stable(o_prdata) && $stable(o_pslverr);
  endproperty
  a_stands: assert property (p_stands)
    else $error("answer moved after access");
  property p_quiet;
    $fell(i_rst) |-> o_route_a == '0 && o_route_b == '0 && o_local == '0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("outputs not clear after reset");
  property p_carry_pass;
    $fell(i_rst) |-> o_carry_out == i_carry_in;
  endproperty
  a_carry_pass: assert property (p_carry_pass)
    else $error("carry not passed through normal cells");
  property p_chain_seen;
    i_psel && !i_penable && !i_pwrite && is_stat
      |=> o_prdata[N_CELLS-1] == $past(o_reg_chain_out);
  endproperty
  a_chain_seen: assert property (p_chain_seen)
    else $error("chain output differs from last cell state");
endmodule

bind cell_cluster cell_cluster_props #(.N_CELLS(N_CELLS)) props_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_carry_in(i_carry_in), .o_route_a(o_route_a), .o_route_b(o_route_b),
  .o_local(o_local), .o_carry_out(o_carry_out),
  .o_reg_chain_out(o_reg_chain_out));

`default_nettype wire

// file: dv/cluster_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none

// neighbouring logic driving one cluster clock pin
module cluster_pin_driver (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // request and pin
  input  wire logic i_go,
  output logic      o_clock,
  output logic      o_busy
);
  logic [2:0] phase;

  // pin clock pulse
  // three cycles high, three low, so the filter always sees it; still between
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      phase <= 3'h0;
    else if (phase == 3'h6)
      phase <= 3'h0;
    else if (phase != 3'h0 || i_go)
      phase <= phase + 3'h1;

  assign o_clock = phase != 3'h0 && phase < 3'h4;
  assign o_busy  = phase != 3'h0;
endmodule

`default_nettype wire

// file: dv/test_cell_cluster.sv
`timescale 1ns/1ps
`default_nettype none

module test_cell_cluster;
  localparam logic [31:0] TO_FLOP = 32'h1 << cell_cluster_pkg::F_OUT_SEL;
  localparam logic [31:0] CLR_EN  = 32'h1 << cell_cluster_pkg::F_CLR_EN;
  localparam logic [31:0] CHAIN   = 32'h1 << cell_cluster_pkg::F_CHAIN_SEL;
  localparam logic [31:0] PACK    = 32'h1 << cell_cluster_pkg::F_PACK;
  localparam logic [31:0] ARITH   = 32'h1 << cell_cluster_pkg::F_ARITH;
  localparam logic [31:0] PRESET  = 32'h1 << cell_cluster_pkg::F_PRESET;
  localparam logic [31:0] TOGGLE  = 32'(cell_cluster_pkg::FF_T)
                                    << cell_cluster_pkg::F_FF_TYPE;
  localparam logic [31:0] SIDE_B  = (32'h1 << cell_cluster_pkg::F_CLK_SEL)
                                    | (32'h1 << cell_cluster_pkg::F_CLR_SEL);
  // stimulus and observed signals
  logic        i_clk, i_rst, psel, penable, pwrite, go, ena, clr, sclr, sld;
  logic        rst_n, cin, ch_in, e, c;
  logic [11:0] paddr;
  logic [31:0] pwdata, r, w, shadow;
  logic [15:0] d0, d1, d2, d3, q, use3, s;
  logic [15:0] tab [16];
  wire logic        pready, pslverr, clk_a, busy, cout, ch_out;
  wire logic [31:0] prdata;
  wire logic [15:0] ra, rb, rl;
  integer      errors, n_compared, seed;

  cell_cluster #(.N_CELLS(16)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_cluster_clock_a(clk_a),
    .i_cluster_clock_b(clk_a), .i_cluster_clock_enable_a(ena),
    .i_cluster_clock_enable_b(ena), .i_cluster_async_clear_a(clr),
    .i_cluster_async_clear_b(clr), .i_sync_clear(sclr), .i_sync_load(sld),
    .i_chip_wide_reset_n(rst_n), .i_data0(d0), .i_data1(d1), .i_data2(d2),
    .i_fourth_data_input(d3), .i_carry_in(cin), .i_reg_chain_in(ch_in),
    .o_route_a(ra), .o_route_b(rb), .o_local(rl), .o_carry_out(cout),
    .o_reg_chain_out(ch_out));
  cluster_pin_driver pin_u (.i_clk(i_clk), .i_rst(i_rst), .i_go(go),
    .o_clock(clk_a), .o_busy(busy));

  task automatic report_and_stop;
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic exp, input logic got);
    chk_word({31'h0, exp}, {31'h0, got});
  endtask

  // one apb transfer; held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge i_clk);
    end
    // a slave that never answers counts against the run
    if (pready !== 1'b1)
      errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic set_cells(input logic [31:0] extra);
    for (int k = 0; k < 16; k++)
      apb(1'b1, cell_cluster_pkg::OFS_CELL0 + 12'(4 * k), extra
          | 32'(tab[k]) | (32'(use3[k]) << cell_cluster_pkg::F_CIN_SEL));
  endtask

  task automatic rnd_data;
    @(posedge i_clk);
    d0 <= 16'($random(seed)); d1 <= 16'($random(seed));
    d2 <= 16'($random(seed)); d3 <= 16'($random(seed));
    cin <= 1'($random(seed)); ch_in <= 1'($random(seed));
    @(posedge i_clk);
  endtask

  // one cluster clock pulse, then the filter delay
  task automatic pulse;
    int n;
    n = 0;
    @(posedge i_clk) go <= 1'b1;
    @(posedge i_clk) go <= 1'b0;
    do @(posedge i_clk); while (busy !== 1'b0 && ++n < 20);
    if (busy !== 1'b0)
      errors++;
    repeat (2) @(posedge i_clk);
  endtask

  function automatic logic [15:0] lut_vec;
    for (int k = 0; k < 16; k++)
      lut_vec[k] = tab[k][{use3[k] ? cin : d3[k], d2[k], d1[k], d0[k]}];
  endfunction

  // clock and watchdog
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    #100000;
    errors++;
    report_and_stop;
  end

  initial
  begin
    {psel, penable, pwrite, go, ena, clr, sclr, sld, cin, ch_in} = '0;
    {paddr, pwdata, d0, d1, d2, d3, use3} = '0;
    errors = 0; n_compared = 0; seed = 32'h95b2; rst_n = 1'b1; i_rst = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values of control and status
    apb(1'b0, cell_cluster_pkg::OFS_CTRL, 32'h0);
    chk_word(cell_cluster_pkg::CTRL_RESET, r);
    apb(1'b0, cell_cluster_pkg::OFS_STATUS, 32'h0);
    chk_word({11'h0, cell_cluster_pkg::PIN_RESET, 16'h0}, r);
    apb(1'b0, 12'h008, 32'h0);
    chk_flag(1'b1, e);
    apb(1'b0, 12'h080, 32'h0);
    chk_word(32'h0, r);
    apb(1'b1, cell_cluster_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    chk_flag(1'b1, e);
    // non-global budget, four allowed, five refused
    shadow = cell_cluster_pkg::CTRL_RESET;
    for (int i = 0; i < 14; i++)
    begin
      w = i == 0 ? 32'h0000_1F00 : i == 1 ? 32'h0000_0F00
          : 32'($random(seed)) & 32'h00FF_FF07;
      apb(1'b1, cell_cluster_pkg::OFS_CTRL, w);
      c = $countones(w[15:8] & ~w[23:16]) > 4;
      chk_flag(c, e);
      shadow = c ? shadow : w;
      apb(1'b0, cell_cluster_pkg::OFS_CTRL, 32'h0);
      chk_word(shadow, r);
    end
    // packing and synchronous load exclude each other
    apb(1'b1, cell_cluster_pkg::OFS_CTRL, 32'h00FF_8000);
    apb(1'b1, cell_cluster_pkg::OFS_CELL0, PACK);
    chk_flag(1'b1, e);
    apb(1'b1, cell_cluster_pkg::OFS_CTRL, 32'h00FF_0000);
    apb(1'b1, cell_cluster_pkg::OFS_CELL0, PACK);
    apb(1'b1, cell_cluster_pkg::OFS_CTRL, 32'h00FF_8000);
    chk_flag(1'b1, e);
    // normal tables, carry or fourth input
    for (int k = 0; k < 16; k++)
      tab[k] = 16'($random(seed));
    use3 = 16'($random(seed));
    set_cells(32'h0);
    repeat (8)
    begin
      rnd_data;
      chk_word({16'h0, lut_vec()}, {16'h0, ra});
      chk_word({lut_vec(), lut_vec()}, {rb, rl});
    end
    set_cells(ARITH);
    repeat (8)
    begin
      rnd_data;
      c = cin;
      for (int k = 0; k < 16; k++)
      begin
        s[k] = d0[k] ^ d1[k] ^ c;
        c = (d0[k] & d1[k]) | (c & (d0[k] ^ d1[k]));
      end
      chk_word({16'h0, s}, {16'h0, ra});
      chk_flag(c, cout);
    end
    // registered table, enable, load, clear, chip reset
    use3 = 16'h0;
    apb(1'b1, cell_cluster_pkg::OFS_CTRL, 32'h00FF_D501);
    set_cells(TO_FLOP | CLR_EN);
    ena <= 1'b1;
    rnd_data;
    pulse;
    q = lut_vec();
    chk_word({16'h0, q}, {16'h0, ra});
    chk_word({16'h0, lut_vec()}, {16'h0, rb});
    ena <= 1'b0;
    rnd_data;
    pulse;
    chk_word({16'h0, q}, {16'h0, ra});
    ena <= 1'b1; sld <= 1'b1;
    pulse;
    chk_word({16'h0, d3}, {16'h0, ra});
    sclr <= 1'b1;
    pulse;
    chk_word(32'h0, {16'h0, ra});
    sclr <= 1'b0;
    pulse;
    ena <= 1'b0; clr <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk_word(32'h0, {16'h0, ra});
    clr <= 1'b0; ena <= 1'b1;
    pulse;
    rst_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk_word(32'h0, {16'h0, ra});
    rst_n <= 1'b1; sld <= 1'b0;
    // register chain shifts through all cells
    set_cells(TO_FLOP | CHAIN);
    q = 16'h0;
    repeat (18)
    begin
      rnd_data;
      pulse;
      q = {q[14:0], ch_in};
      chk_word({16'h0, q}, {16'h0, ra});
      chk_flag(q[15], ch_out);
    end
    apb(1'b0, cell_cluster_pkg::OFS_STATUS, 32'h0);
    chk_word({16'h0, q}, {16'h0, r[15:0]});
    // odd cells on clock b falling, even on clock a rising
    // preset cells read one after a clear, then toggle
    apb(1'b1, cell_cluster_pkg::OFS_CTRL, 32'h00FF_3F05);
    for (int k = 0; k < 16; k++)
      apb(1'b1, cell_cluster_pkg::OFS_CELL0 + 12'(4 * k), 32'h0000_FFFF
          | TO_FLOP | CLR_EN | PRESET | TOGGLE
          | ((k % 2 == 1) ? SIDE_B : 32'h0000_0000));
    clr <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk_word(32'h0000_FFFF, {16'h0, ra});
    clr <= 1'b0;
    q = 16'hFFFF;
    repeat (2)
    begin
      pulse;
      q = ~q;
      chk_word({16'h0, q}, {16'h0, ra});
    end
    report_and_stop;
  end
endmodule

`default_nettype wire

// file: rtl/cell_cluster.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - cluster holds sixteen cells sharing cluster resources
// - six cell inputs: four data, carry, chain
// - three outputs: two routing, one local
// - packing: table and register drive outputs independently
// - synchronous load refused for packing cells
// - register chain feeds next cell's flip-flop
// - flip-flop acts as D, T, JK or SR
// - flip-flop has clock, clear, clock enable
// - combinational use bypasses the flip-flop
// - feedback returns register output into own table
// - normal mode: table with carry or fourth input
// - arithmetic mode: full adder with carry propagation
// - carry ripples serially, continues to next cluster
// - two clocks, enables, clears, sync clear, load
// - each clock paired with its own enable
// - both edges need both clock resources
// - enable low holds flip-flops on that clock
// - sync clear hits every flip-flop, load every one except in packing cells
// - eight control signals, at most four non-global
// - no preset line; preset by inverting around clear
// - enabled chip reset clears all, overrides everything
module cell_cluster #(
  parameter int N_CELLS = 16
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // apb slave
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [11:0]         i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic                     o_pready,
  output logic [31:0]              o_prdata,
  output logic                     o_pslverr,
  // cluster-wide control pins
  input  wire logic                i_cluster_clock_a,
  input  wire logic                i_cluster_clock_b,
  input  wire logic                i_cluster_clock_enable_a,
  input  wire logic                i_cluster_clock_enable_b,
  input  wire logic                i_cluster_async_clear_a,
  input  wire logic                i_cluster_async_clear_b,
  input  wire logic                i_sync_clear,
  input  wire logic                i_sync_load,
  input  wire logic                i_chip_wide_reset_n,
  // per-cell data from local interconnect
  input  wire logic [N_CELLS-1:0]  i_data0,
  input  wire logic [N_CELLS-1:0]  i_data1,
  input  wire logic [N_CELLS-1:0]  i_data2,
  input  wire logic [N_CELLS-1:0]  i_fourth_data_input,
  // chains from the cluster below
  input  wire logic                i_carry_in,
  input  wire logic                i_reg_chain_in,
  // per-cell routing outputs
  output logic [N_CELLS-1:0]       o_route_a,
  output logic [N_CELLS-1:0]       o_route_b,
  output logic [N_CELLS-1:0]       o_local,
  // chains to the cluster above
  output logic                     o_carry_out,
  output logic                     o_reg_chain_out
);

  // refuse cluster sizes the address map cannot hold
  // sixteen cell ceiling
  if (N_CELLS < 1 || N_CELLS > cell_cluster_pkg::CELLS_MAX)
  begin : g_size_check
    $error("N_CELLS must lie between 1 and 16");
  end

  // count ones in a control signal mask
  function automatic logic [3:0] count_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // next value of one flip-flop for its configured personality
  function automatic logic ff_next(
    input cell_cluster_pkg::ff_type_t t,
    input logic q,
    input logic d,
    input logic aux
  );
    logic r;
    r = d;
    case (t)
      cell_cluster_pkg::FF_D:  r = d;
      cell_cluster_pkg::FF_T:  r = q ^ d;
      cell_cluster_pkg::FF_JK: r = (d & ~q) | (~aux & q);
      cell_cluster_pkg::FF_SR: r = d | (~aux & q);
      default:                 r = d;
    endcase
    return r;
  endfunction

  // configuration state
  logic [31:0]        ctrl;
  logic [31:0]        cell_cfg [N_CELLS];
  logic [N_CELLS-1:0] state;
  logic [N_CELLS-1:0] next_state;

  // per-cell views built in the generate loop
  logic [N_CELLS-1:0] q_vec;
  logic [N_CELLS-1:0] carry;
  logic [N_CELLS-1:0] pack_vec;

  // pin synchroniser stages and filtered levels
  logic [cell_cluster_pkg::PINS-1:0] sync1;
  logic [cell_cluster_pkg::PINS-1:0] sync2;
  logic [cell_cluster_pkg::PINS-1:0] sync3;
  logic [cell_cluster_pkg::PINS-1:0] pin_lvl;
  logic [cell_cluster_pkg::PINS-1:0] next_pin_lvl;

  wire [cell_cluster_pkg::PINS-1:0] pin_raw =
  {
    i_chip_wide_reset_n,
    i_cluster_async_clear_b,
    i_cluster_async_clear_a,
    i_cluster_clock_b,
    i_cluster_clock_a
  };

  // three flops per pin; the first is read only by the second
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1   <= cell_cluster_pkg::PIN_RESET;
      sync2   <= cell_cluster_pkg::PIN_RESET;
      sync3   <= cell_cluster_pkg::PIN_RESET;
      pin_lvl <= cell_cluster_pkg::PIN_RESET;
    end
    else
    begin
      sync1   <= pin_raw;
      sync2   <= sync1;
      sync3   <= sync2;
      pin_lvl <= next_pin_lvl;
    end
  end

  // a level change counts only once stages two and three agree,
  // which rejects a single-sample glitch on a slow pin
  wire [cell_cluster_pkg::PINS-1:0] agree = ~(sync2 ^ sync3);
  wire [cell_cluster_pkg::PINS-1:0] rise  = agree & sync2 & ~pin_lvl;
  wire [cell_cluster_pkg::PINS-1:0] fall  = agree & ~sync2 & pin_lvl;
  assign next_pin_lvl = (agree & sync2) | (~agree & pin_lvl);

  // control signals gated by the usage mask
  // the global mask only matters when a control word is written
  wire [7:0] used   = ctrl[cell_cluster_pkg::C_USED +: 8];

  wire edge_a = used[cell_cluster_pkg::CS_CLK_A] &
    (ctrl[cell_cluster_pkg::C_EDGE_A] ?
     fall[cell_cluster_pkg::P_CLK_A] : rise[cell_cluster_pkg::P_CLK_A]);
  wire edge_b = used[cell_cluster_pkg::CS_CLK_B] &
    (ctrl[cell_cluster_pkg::C_EDGE_B] ?
     fall[cell_cluster_pkg::P_CLK_B] : rise[cell_cluster_pkg::P_CLK_B]);

  // enable a goes with clock a, b with b
  wire ena_a = ~used[cell_cluster_pkg::CS_ENA_A] |
    i_cluster_clock_enable_a;
  wire ena_b = ~used[cell_cluster_pkg::CS_ENA_B] |
    i_cluster_clock_enable_b;
  wire tick_a = edge_a & ena_a;
  wire tick_b = edge_b & ena_b;

  // async clears follow the filtered pin level, not the clock
  wire clr_a = used[cell_cluster_pkg::CS_CLR_A] &
    pin_lvl[cell_cluster_pkg::P_CLR_A];
  wire clr_b = used[cell_cluster_pkg::CS_CLR_B] &
    pin_lvl[cell_cluster_pkg::P_CLR_B];

  wire sclr  = used[cell_cluster_pkg::CS_SCLR] & i_sync_clear;
  wire sload = used[cell_cluster_pkg::CS_SLOAD] & i_sync_load;

  // chip reset only when its option is set
  wire chip_rst = ctrl[cell_cluster_pkg::C_RESET_EN] &
    ~pin_lvl[cell_cluster_pkg::P_RST_N];

  // the sixteen logic cells
  for (genvar k = 0; k < N_CELLS; k++)
  begin : g_cell
    wire [31:0] cfg = cell_cfg[k];
    wire arith   = cfg[cell_cluster_pkg::F_ARITH];
    wire pack    = cfg[cell_cluster_pkg::F_PACK];
    wire fb      = cfg[cell_cluster_pkg::F_FEEDBACK];
    wire preset  = cfg[cell_cluster_pkg::F_PRESET];
    wire [2:0] osel = cfg[cell_cluster_pkg::F_OUT_SEL +: 3];

    // stored bit is inverted under preset
    wire q = state[k] ^ preset;

    // carry-in and chain from the cell below
    wire cin;
    wire chain_in;
    if (k == 0)
    begin : g_head
      assign cin      = i_carry_in;
      assign chain_in = i_reg_chain_in;
    end
    else
    begin : g_link
      // cell zero has no lower neighbour, so no index below zero is built
      assign cin      = carry[k-1];
      assign chain_in = q_vec[k-1];
    end

    wire d2 = fb ? q : i_data2[k];
    // carry or fourth input into the table
    wire in3 = cfg[cell_cluster_pkg::F_CIN_SEL] ?
      cin : i_fourth_data_input[k];
    wire [3:0] idx = {in3, d2, i_data1[k], i_data0[k]};
    wire lut = cfg[cell_cluster_pkg::F_LUT + 32'(idx)];

    // full adder, feedback makes an accumulator
    wire add_a = fb ? q : i_data0[k];
    wire add_b = i_data1[k];
    wire sum   = add_a ^ add_b ^ cin;
    wire cout  = (add_a & add_b) | (cin & (add_a ^ add_b));
    wire comb  = arith ? sum : lut;

    // normal cells pass the carry so a chain may cross them
    assign carry[k] = arith ? cout : cin;

    // packed register takes the fourth input directly
    wire d_src = cfg[cell_cluster_pkg::F_CHAIN_SEL] ? chain_in :
      (pack ? i_fourth_data_input[k] : comb);

    wire d_next = ff_next(
      cell_cluster_pkg::ff_type_t'(cfg[cell_cluster_pkg::F_FF_TYPE +: 2]),
      q, d_src, i_data2[k]);

    wire tick = cfg[cell_cluster_pkg::F_CLK_SEL] ? tick_b : tick_a;
    wire aclr = cfg[cell_cluster_pkg::F_CLR_EN] &
      (cfg[cell_cluster_pkg::F_CLR_SEL] ? clr_b : clr_a);

    // load never reaches a packing cell
    wire load_k = sload & ~pack;

    wire q_sync = sclr ? 1'b0 :
      (load_k ? i_fourth_data_input[k] : d_next);

    // chip reset and async clear beat any edge
    assign next_state[k] = (chip_rst | aclr) ? 1'b0 :
      (tick ? (q_sync ^ preset) : state[k]);

    assign q_vec[k]    = q;
    assign pack_vec[k] = pack;

    // two routing outputs and one local
    // a clear select bit bypasses the flip-flop
    assign o_route_a[k] = osel[0] ? q : comb;
    assign o_route_b[k] = osel[1] ? q : comb;
    assign o_local[k]   = osel[2] ? q : comb;
  end

  // cell flip-flops all advance on the one system clock
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // chain ends toward the cluster above
  assign o_carry_out     = carry[N_CELLS-1];
  assign o_reg_chain_out = q_vec[N_CELLS-1];

  // apb phase decode
  wire setup  = i_psel & ~i_penable;
  wire access = i_psel & i_penable;

  wire hit_ctrl   = (i_paddr == cell_cluster_pkg::OFS_CTRL);
  wire hit_status = (i_paddr == cell_cluster_pkg::OFS_STATUS);
  wire [3:0] cell_idx = i_paddr[5:2];
  wire hit_cell = (i_paddr[11:6] == cell_cluster_pkg::OFS_CELL0[11:6]) &&
    (i_paddr[1:0] == 2'h0) && (32'(cell_idx) < N_CELLS);

  wire [7:0] wr_used   = i_pwdata[cell_cluster_pkg::C_USED +: 8];
  wire [7:0] wr_global = i_pwdata[cell_cluster_pkg::C_GLOBAL +: 8];
  wire over_budget = count_ones(wr_used & ~wr_global) >
    4'(cell_cluster_pkg::NONGLOBAL_MAX);

  // packing and load may not coexist
  wire ctrl_bad = over_budget |
    (wr_used[cell_cluster_pkg::CS_SLOAD] & (|pack_vec));
  wire cell_bad = i_pwdata[cell_cluster_pkg::F_PACK] &
    used[cell_cluster_pkg::CS_SLOAD];

  // a refused write leaves every register untouched
  wire req_err = ~(hit_ctrl | hit_status | hit_cell) |
    (i_pwrite & hit_status) |
    (i_pwrite & hit_ctrl & ctrl_bad) |
    (i_pwrite & hit_cell & cell_bad);

  // read selection; status shows cell register bits and pin levels
  wire [31:0] status_word = {11'h000, pin_lvl, 16'(q_vec)};
  wire [31:0] read_word = hit_ctrl ? ctrl :
    hit_status ? status_word :
    hit_cell ? cell_cfg[cell_idx] : 32'h0000_0000;

  // zero-wait slave: answer prepared in setup, ready in access
  assign o_pready = access;

  // read data and error are latched while the master sets up
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (setup)
    begin
      o_prdata  <= i_pwrite ? 32'h0000_0000 : read_word;
      o_pslverr <= req_err;
    end
  end

  wire do_write = access & i_pwrite & ~o_pslverr;

  // cluster control register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl <= cell_cluster_pkg::CTRL_RESET;
    end
    else if (do_write && hit_ctrl)
    begin
      ctrl <= i_pwdata;
    end
  end

  // per-cell configuration words
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < N_CELLS; i++)
      begin
        cell_cfg[i] <= cell_cluster_pkg::CELL_RESET;
      end
    end
    else if (do_write && hit_cell)
    begin
      cell_cfg[cell_idx] <= i_pwdata;
    end
  end

endmodule

`default_nettype wire

// file: rtl/cell_cluster_pkg.sv
`default_nettype none

package cell_cluster_pkg;

  // register byte offsets on the APB slave
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CELL0  = 12'h040;

  // cluster sizing and control signal budget
  localparam int CELLS_MAX        = 16;
  localparam int CTRL_SIGNALS_MAX = 8;
  localparam int NONGLOBAL_MAX    = 4;

  // cell configuration word fields
  localparam int F_LUT       = 0;
  localparam int F_ARITH     = 16;
  localparam int F_FF_TYPE   = 17;
  localparam int F_PACK      = 19;
  localparam int F_FEEDBACK  = 20;
  localparam int F_CIN_SEL   = 21;
  localparam int F_CLK_SEL   = 22;
  localparam int F_CLR_SEL   = 23;
  localparam int F_CLR_EN    = 24;
  localparam int F_PRESET    = 25;
  localparam int F_CHAIN_SEL = 26;
  localparam int F_OUT_SEL   = 27;

  // cluster control word fields
  localparam int C_RESET_EN = 0;
  localparam int C_EDGE_A   = 1;
  localparam int C_EDGE_B   = 2;
  localparam int C_USED     = 8;
  localparam int C_GLOBAL   = 16;

  // control signal slots inside the used and global masks
  localparam int CS_CLK_A = 0;
  localparam int CS_CLK_B = 1;
  localparam int CS_ENA_A = 2;
  localparam int CS_ENA_B = 3;
  localparam int CS_CLR_A = 4;
  localparam int CS_CLR_B = 5;
  localparam int CS_SCLR  = 6;
  localparam int CS_SLOAD = 7;

  // synchronised pin slots
  localparam int PINS    = 5;
  localparam int P_CLK_A = 0;
  localparam int P_CLK_B = 1;
  localparam int P_CLR_A = 2;
  localparam int P_CLR_B = 3;
  localparam int P_RST_N = 4;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h00FF_FF01;
  localparam logic [31:0] CELL_RESET = 32'h0000_0000;
  localparam logic [4:0]  PIN_RESET  = 5'h10;

  // flip-flop personalities
  typedef enum logic [1:0]
  {
    FF_D  = 2'h0,
    FF_T  = 2'h1,
    FF_JK = 2'h2,
    FF_SR = 2'h3
  } ff_type_t;

endpackage

`default_nettype wire
